// >>> hdl/bp_timing_pkg.sv
package bp_timing_pkg;

  // Number of bused trigger lines on the backplane.
  localparam int unsigned BUS_TRIG_W = 8;
  // Link clock figures: 10 MHz sync sampled at the 250 MHz core clock.
  localparam int unsigned CORE_CLK_MHZ = 250;
  localparam int unsigned SYNC_CLK_MHZ = 10;
  // Core cycles in one legacy 10 MHz period.
  localparam int unsigned LEGACY_PERIOD_CYC = CORE_CLK_MHZ / SYNC_CLK_MHZ;
  localparam logic [4:0] LEGACY_LAST = 5'(LEGACY_PERIOD_CYC - 1);
  // Reference edges with no gap that declare lock.
  localparam logic [3:0] LOCK_EDGES = 4'h8;
  // Longest gap between reference edges, in core cycles, before lock drops.
  localparam logic [3:0] REF_GAP_MAX = 4'h6;
  localparam logic [1:0] SYNC_STAGES_RST = 2'h0;

  // Reference source choice; the legacy 10 MHz clock is listed but flagged invalid.
  typedef enum logic [1:0] {
    REF_NONE,
    REF_CLK100,
    REF_LEGACY10
  } ref_sel_type;

  // Trigger source choice for acquisition start.
  typedef enum logic [2:0] {
    TRIG_SRC_NONE,
    TRIG_SRC_BUS,
    TRIG_SRC_STAR,
    TRIG_SRC_DSTAR_B
  } trig_src_type;

  typedef enum logic {
    OUT_SRC_TRIG,
    OUT_SRC_CLK
  } out_src_type;

  // Backplane pins seen by the module.
  typedef struct packed {
    logic clk100;
    logic sync100;
    logic clk10;
    logic star;
    logic dstar_a;
    logic dstar_b;
    logic [BUS_TRIG_W-1:0] bus_trig;
  } bp_in_type;

  // User configuration of the block.
  typedef struct packed {
    ref_sel_type ref_sel;
    trig_src_type trig_src;
    logic [2:0] bus_trig_idx;
    logic [2:0] sync_line_idx;
    out_src_type out_src;
    logic timing_module_present;
  } cfg_type;

endpackage

// >>> hdl/backplane_clock_trigger_interface.sv
`timescale 1ns/1ps
// Operation
// [R1] Backplane sends 100 MHz reference per slot.
// [R2] Backplane sends 10 MHz sync, 10% high.
// [R3] Sync clock regenerates legacy 10 MHz edges.
// [R4] Legacy 10 MHz aligned to 100 MHz.
// [R5] Legacy 10 MHz never accepted as reference.
// [R6] Chassis provides eight bused trigger lines.
// [R7] Bused triggers driven here reach other modules.
// [R8] Chassis routes star trigger from timing slot.
// [R9] Star trigger selectable as acquisition trigger.
// [R10] Module never drives the star trigger.
// [R11] Differential star A is a clock input.
// [R12] Differential star B is a trigger input.
// [R13] Differential star C is module output.
// [R14] Differential star lines need timing module.
// [R15] Sync pulse on bus resets converter clocks.
// [R16] Lock internal timing to 100 MHz reference.
// [R17] Synchronise every backplane input before use.
module backplane_clock_trigger_interface
  import bp_timing_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Backplane pins
  input wire bp_in_type bp_i,
  // Configuration
  input wire cfg_type cfg_i,
  // Trigger driven by this module onto a bused line
  input wire logic trig_drive_i,
  input wire logic [2:0] trig_drive_idx_i,
  // Bused trigger pins, open drain
  output logic [BUS_TRIG_W-1:0] bus_trig_o,
  output logic [BUS_TRIG_W-1:0] bus_trig_oe_o,
  // Star trigger pin
  output logic star_o,
  output logic star_oe_o,
  // Differential star C pin
  output logic dstar_c_o,
  output logic dstar_c_oe_o,
  // Status and events toward the acquisition logic
  output logic ref_locked_o,
  output logic ref_invalid_o,
  output logic legacy_tick_o,
  output logic acq_trig_o,
  output logic conv_sync_o
);

  typedef struct packed {
    bp_in_type meta;
    bp_in_type sync;
    bp_in_type prev;
    logic [3:0] lock_cnt;
    logic [3:0] gap_cnt;
    logic locked;
    logic [4:0] phase;
    logic aligned;
    logic legacy_tick;
    logic acq_trig;
    logic conv_sync;
    logic [BUS_TRIG_W-1:0] bus_oe;
    logic dstar_c;
    logic dstar_c_oe;
    logic ref_invalid;
  } state_type;

  state_type s_q;
  state_type s_d;

  always_comb begin
    logic ref_ok;
    logic clk_rise;
    logic sync_rise;
    logic bus_rise;
    logic sync_line_rise;
    logic dstar_ok;
    ref_ok = 1'b0;
    clk_rise = 1'b0;
    sync_rise = 1'b0;
    bus_rise = 1'b0;
    sync_line_rise = 1'b0;
    dstar_ok = 1'b0;
    s_d = s_q;
    s_d.meta = bp_i;
    s_d.sync = s_q.meta; // see [R17]
    s_d.prev = s_q.sync;
    // The legacy 10 MHz clock is never a reference, only the 100 MHz one.
    ref_ok = (cfg_i.ref_sel == REF_CLK100); // see [R5]
    s_d.ref_invalid = (cfg_i.ref_sel == REF_LEGACY10); // see [R5]
    clk_rise = s_q.sync.clk100 & ~s_q.prev.clk100;
    sync_rise = s_q.sync.sync100 & ~s_q.prev.sync100;
    bus_rise = s_q.sync.bus_trig[cfg_i.bus_trig_idx] &
      ~s_q.prev.bus_trig[cfg_i.bus_trig_idx];
    sync_line_rise = s_q.sync.bus_trig[cfg_i.sync_line_idx] &
      ~s_q.prev.bus_trig[cfg_i.sync_line_idx];
    dstar_ok = cfg_i.timing_module_present; // see [R14]
    // Lock is declared after a run of reference edges with no long gap.
    if (!ref_ok) begin // see [R16]
      s_d.lock_cnt = 4'h0;
      s_d.gap_cnt = 4'h0;
      s_d.locked = 1'b0;
    end else if (clk_rise) begin
      s_d.gap_cnt = 4'h0;
      if (s_q.lock_cnt != LOCK_EDGES) begin
        s_d.lock_cnt = s_q.lock_cnt + 4'h1;
      end
      s_d.locked = (s_q.lock_cnt + 4'h1 >= LOCK_EDGES); // see [R16]
    end else if (s_q.gap_cnt == REF_GAP_MAX) begin
      s_d.lock_cnt = 4'h0;
      s_d.locked = 1'b0;
    end else begin
      s_d.gap_cnt = s_q.gap_cnt + 4'h1;
    end
    // Legacy edges free-run off the core clock but are re-phased to each
    // sync edge, so they inherit the low skew of the 100 MHz timebase.
    // Free-running wraps only tick once a sync edge has set the phase.
    // Otherwise a wrap just before the first sync edge after lock would
    // give two legacy edges a few cycles apart.
    s_d.legacy_tick = 1'b0;
    if (!s_q.locked) begin
      s_d.aligned = 1'b0;
      s_d.phase = 5'h00;
    end else if (sync_rise) begin // see [R3]
      s_d.aligned = 1'b1;
      s_d.phase = 5'h00;
      s_d.legacy_tick = 1'b1;
    end else if (s_q.phase == LEGACY_LAST) begin
      s_d.phase = 5'h00;
      s_d.legacy_tick = s_q.aligned; // see [R3]
    end else begin
      s_d.phase = s_q.phase + 5'h01;
    end
    s_d.conv_sync = sync_line_rise; // see [R15]
    unique case (cfg_i.trig_src)
      TRIG_SRC_BUS: s_d.acq_trig = bus_rise; // see [R7]
      TRIG_SRC_STAR: s_d.acq_trig = s_q.sync.star & ~s_q.prev.star; // see [R9]
      TRIG_SRC_DSTAR_B: s_d.acq_trig = dstar_ok & s_q.sync.dstar_b &
        ~s_q.prev.dstar_b; // see [R12]
      default: s_d.acq_trig = 1'b0;
    endcase
    // Open drain: a low is driven while the trigger is asserted.
    s_d.bus_oe = '0;
    s_d.bus_oe[trig_drive_idx_i] = trig_drive_i; // see [R7]
    s_d.dstar_c_oe = dstar_ok; // see [R13]
    s_d.dstar_c = (cfg_i.out_src == OUT_SRC_CLK) ? s_q.sync.dstar_a &
      dstar_ok : trig_drive_i; // see [R11]
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_trig_o = '0;
  assign bus_trig_oe_o = s_q.bus_oe;
  assign star_o = 1'b0;
  assign star_oe_o = 1'b0; // see [R10]
  assign dstar_c_o = s_q.dstar_c;
  assign dstar_c_oe_o = s_q.dstar_c_oe;
  assign ref_locked_o = s_q.locked;
  assign ref_invalid_o = s_q.ref_invalid;
  assign legacy_tick_o = s_q.legacy_tick;
  assign acq_trig_o = s_q.acq_trig;
  assign conv_sync_o = s_q.conv_sync;

endmodule // backplane_clock_trigger_interface

// >>> tb/bp_timing_props.sv
`timescale 1ns/1ps
module bp_timing_props
  import bp_timing_pkg::*;
(
  // Block inputs
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire bp_in_type bp_i,
  input wire cfg_type cfg_i,
  input wire logic trig_drive_i,
  input wire logic [2:0] trig_drive_idx_i,
  // Block outputs
  input wire logic [BUS_TRIG_W-1:0] bus_trig_o,
  input wire logic [BUS_TRIG_W-1:0] bus_trig_oe_o,
  input wire logic star_o, star_oe_o, dstar_c_o, dstar_c_oe_o,
  input wire logic ref_locked_o, ref_invalid_o, legacy_tick_o,
  input wire logic acq_trig_o, conv_sync_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  star_quiet_a: assert property (!star_o && !star_oe_o)
    else $error("star pin driven");
  bus_low_a: assert property (bus_trig_o == '0)
    else $error("bused line driven high");
  drive_oe_a: assert property (trig_drive_i |=>
    bus_trig_oe_o[$past(trig_drive_idx_i)]) else $error("drive missing");
  no_dstar_a: assert property (!cfg_i.timing_module_present |=>
    !dstar_c_oe_o) else $error("star line C driven alone");
  legacy_flag_a: assert property (cfg_i.ref_sel == REF_LEGACY10 |=>
    ref_invalid_o) else $error("legacy reference not flagged");
  acq_pulse_a: assert property (acq_trig_o |=> !acq_trig_o)
    else $error("trigger pulse too long");
  sync_pulse_a: assert property (conv_sync_o |=> !conv_sync_o)
    else $error("sync pulse too long");
  tick_gap_a: assert property (legacy_tick_o |=> !legacy_tick_o [*8])
    else $error("legacy ticks too close");
  cover property (acq_trig_o);
  cover property (conv_sync_o);
  cover property (ref_locked_o);
endmodule // bp_timing_props
bind backplane_clock_trigger_interface bp_timing_props u_bp_timing_props (.*);

// >>> tb/bp_backplane_model.sv
`timescale 1ns/1ps
module bp_backplane_model (
  // Control
  input wire logic run_i,
  // Backplane clocks
  output logic clk100_o,
  output logic sync100_o,
  output logic clk10_o,
  output logic dstar_a_o
);
  // The reference stands low while stopped, so a loss of lock can be shown.
  initial begin
    clk100_o = 1'b0;
    forever #5 clk100_o = run_i & ~clk100_o;
  end
  always begin
    sync100_o = 1'b1;
    #10 sync100_o = 1'b0;
    #90;
  end
  always begin
    clk10_o = 1'b1;
    #50 clk10_o = 1'b0;
    #50;
  end
  initial begin
    dstar_a_o = 1'b0;
    forever #80 dstar_a_o = ~dstar_a_o;
  end
endmodule // bp_backplane_model

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import bp_timing_pkg::*;
  logic clock_i = 1'b0, rstn_i = 1'b0, run = 1'b0, trig_drive_i = 1'b0;
  logic [2:0] trig_drive_idx_i = 3'h3, pin = 3'h0;
  cfg_type cfg_i = '0;
  wire bp_in_type bp_i;
  logic [7:0] bus_trig_o, bus_trig_oe_o;
  logic star_o, star_oe_o, dstar_c_o, dstar_c_oe_o, ref_locked_o;
  logic ref_invalid_o, legacy_tick_o, acq_trig_o, conv_sync_o;
  int mismatches = 0, total_checks = 0, n;
  always #2 clock_i = ~clock_i;
  // A bused line reads low while the module pulls it.
  assign bp_i.bus_trig = {2'h0, pin[2], 5'h0} & ~bus_trig_oe_o;
  assign bp_i.star = pin[1];
  assign bp_i.dstar_b = pin[0];
  bp_backplane_model u_bp_backplane_model (.run_i(run),
    .clk100_o(bp_i.clk100), .sync100_o(bp_i.sync100),
    .clk10_o(bp_i.clk10), .dstar_a_o(bp_i.dstar_a));
  backplane_clock_trigger_interface u_backplane_clock_trigger_interface (.*);
  task chk(input string w, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask
  task conclude;
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task trig(input trig_src_type s, input logic [2:0] p, input int a, c);
    int na, nc;
    na = 0;
    nc = 0;
    cfg_i.trig_src = s;
    repeat (4) @(negedge clock_i);
    pin = p;
    repeat (10) begin
      @(negedge clock_i);
      na += acq_trig_o;
      nc += conv_sync_o;
    end
    pin = 3'h0;
    repeat (6) @(negedge clock_i);
    chk("acq_trig_o", 8'(a), 8'(na));
    chk("conv_sync_o", 8'(c), 8'(nc));
  endtask
  initial begin
    repeat (16) @(negedge clock_i);
    rstn_i = 1'b1;
    cfg_i.timing_module_present = 1'b1;
    cfg_i.bus_trig_idx = 3'h5;
    cfg_i.sync_line_idx = 3'h5;
    trig(TRIG_SRC_BUS, 3'h4, 1, 1);
    trig(TRIG_SRC_BUS, 3'h2, 0, 0);
    trig(TRIG_SRC_STAR, 3'h2, 1, 0);
    trig(TRIG_SRC_DSTAR_B, 3'h1, 1, 0);
    trig(TRIG_SRC_NONE, 3'h7, 0, 1);
    trig_drive_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk("bus_trig_oe_o", 8'h08, bus_trig_oe_o);
    chk("dstar_c", 8'h03, 8'({dstar_c_oe_o, dstar_c_o}));
    chk("star", 8'h00, 8'({star_oe_o, star_o}));
    cfg_i.out_src = OUT_SRC_CLK;
    n = 0;
    repeat (80) @(negedge clock_i) n += dstar_c_o;
    chk("dstar_c_o clock", 8'h28, 8'(n));
    cfg_i.out_src = OUT_SRC_TRIG;
    trig_drive_i = 1'b0;
    cfg_i.timing_module_present = 1'b0;
    trig(TRIG_SRC_DSTAR_B, 3'h1, 0, 0);
    cfg_i.ref_sel = REF_CLK100;
    run = 1'b1;
    repeat (40) @(negedge clock_i);
    chk("ref_locked_o", 8'h01, 8'(ref_locked_o));
    n = 0;
    repeat (100) @(negedge clock_i) n += legacy_tick_o;
    chk("legacy ticks", 8'h04, 8'(n));
    run = 1'b0;
    repeat (20) @(negedge clock_i);
    chk("lost lock", 8'h00, 8'(ref_locked_o));
    cfg_i.ref_sel = REF_LEGACY10;
    run = 1'b1;
    repeat (40) @(negedge clock_i);
    chk("legacy ref", 8'h01, 8'({ref_locked_o, ref_invalid_o}));
    conclude();
  end
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule // tb
